// >>> rtl/safety_status_params.svh
// offsets, fields, reset values, timing and glyph constants of the status and muting block
// What this block does
// - end cap red off, green clear, yellow muting
// - reset required: yellow/red at 1 Hz, outputs off
// - override required: yellow/red at 2 Hz, outputs off
// - rotation flips digit; point lit only unrotated
// - error code shown, held until reset_n goes low
// - sender shows test mode glyph
// - coding shown only just after power-up
// - orange lamp when cleaning or realignment needed
// - receiver green when outputs on, red off
// - extended range glyph only after power-up
// - alignment, interruption, muting, override, blanking glyphs
// - muting only from two wired sensor inputs
// - muting ends at once when condition disappears
// - both sensors active mutes, clear restores
// - cycle runs first activation to last release
// - repeated passages only while pair stays active
// - exit monitoring rejects second passage per cycle
// - unexplained interruption switches outputs off
`ifndef SAFETY_STATUS_PARAMS_SVH
`define SAFETY_STATUS_PARAMS_SVH

`define CTRL_OFFSET       4'h0
`define STATUS_OFFSET     4'h4
`define CTRL_RESET        12'h000
`define CTRL_ROTATE       0
`define CTRL_EXIT_MON     1
`define CTRL_RESET_REQ    2
`define CTRL_OVERRIDE_REQ 3
`define CTRL_TEST_MODE    4
`define CTRL_EXT_RANGE    5
`define CTRL_CODE_LO      6
`define CTRL_REALIGN      8
`define CTRL_POOR_ALIGN   9
`define CTRL_BLANKING     10
`define CTRL_SENDER       11
`define CTRL_WIDTH        12
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`define CLK_HZ            50000000
`define BLINK_HZ          1
`define SHOW_MS           2000
`define HALF_1HZ_CYCLES   (`CLK_HZ / (2 * `BLINK_HZ))
`define SHOW_CYCLES       (`CLK_HZ / 1000 * `SHOW_MS)

`define GLYPH_BLANK       7'h00
`define GLYPH_ERROR       7'h79
`define GLYPH_TEST        7'h5C
`define GLYPH_NOCODE      7'h1C
`define GLYPH_CODE1       7'h40
`define GLYPH_CODE2       7'h48
`define GLYPH_RANGE       7'h76
`define GLYPH_ALIGN       7'h3F
`define GLYPH_BROKEN      7'h06
`define GLYPH_MUTING      7'h54
`define GLYPH_OVERRIDE    7'h73
`define GLYPH_BLANKING    7'h50

`endif

// >>> rtl/safety_status_pkg.sv
// types of the status and muting block
package safety_status_pkg;
    typedef enum logic [3:0]
    {
        MUTE_IDLE  = 4'b0001,
        MUTE_ARMED = 4'b0010,
        MUTE_ON    = 4'b0100,
        MUTE_TAIL  = 4'b1000
    } mute_state_e;
    typedef logic [6:0] glyph_t;
endpackage : safety_status_pkg

// >>> rtl/blink_divider.sv
// divided clock source giving 1 Hz and 2 Hz square waves
`timescale 1ns/100ps
`default_nettype none
module blink_divider #(
    parameter int HALF_CYCLES = 25000000
) (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    output logic      blink_1hz,
    output logic      blink_2hz
);
    localparam int QUARTER = HALF_CYCLES / 2;
    logic [31:0] count;
    logic [31:0] next_count;
    logic [1:0]  phase;
    logic [1:0]  next_phase;

    initial
    begin
        if (HALF_CYCLES < 2)
            $error("blink_divider: HALF_CYCLES below 2");
    end

    always_comb
    begin
        next_count = count;
        next_phase = phase;
        if (clk_en)
        begin
            if (count == 32'(QUARTER - 1))
            begin
                next_count = 32'h0;
                next_phase = phase + 2'h1;
            end
            else
                next_count = count + 32'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= 32'h0;
            phase <= 2'h0;
        end
        else
        begin
            count <= next_count;
            phase <= next_phase;
        end
    end

    // each colour takes one equal half period
    assign blink_1hz = phase[1];
    assign blink_2hz = phase[0];
endmodule : blink_divider
`default_nettype wire

// >>> rtl/safety_status_muting.sv
// status indication and muting cycle logic with an AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "safety_status_params.svh"
module safety_status_muting
    import safety_status_pkg::*;
#(
    parameter int ADDR_W      = 4,
    parameter int HALF_CYCLES = `HALF_1HZ_CYCLES,
    parameter int SHOW_CYCLES = `SHOW_CYCLES
) (
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              first_muting_sensor,
    input  wire logic              second_muting_sensor,
    input  wire logic              beam_interrupted,
    input  wire logic              internal_error,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   outputs_on,
    output logic                   cap_red,
    output logic                   cap_green,
    output logic                   cap_yellow,
    output logic                   lamp_orange,
    output logic                   lamp_red,
    output logic                   lamp_green,
    output logic [6:0]             segments,
    output logic                   segment_point
);
    initial
    begin
        if (ADDR_W < 3 || ADDR_W > 32)
            $error("safety_status_muting: ADDR_W out of range");
        if (SHOW_CYCLES < 1)
            $error("safety_status_muting: SHOW_CYCLES below 1");
    end

    // two-flop synchronisers for the sensor and beam pins
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end
        else if (clk_en)
        begin
            sync_a <= {beam_interrupted, second_muting_sensor, first_muting_sensor};
            sync_b <= sync_a;
        end
    end
    logic sens_1;
    logic sens_2;
    logic beam;
    assign sens_1 = sync_b[0];
    assign sens_2 = sync_b[1];
    assign beam   = sync_b[2];

    // register slave
    logic [`CTRL_WIDTH-1:0] ctrl;
    logic [`CTRL_WIDTH-1:0] next_ctrl;
    logic                   bvalid;
    logic                   next_bvalid;
    logic [1:0]             bresp;
    logic [1:0]             next_bresp;
    logic                   rvalid;
    logic                   next_rvalid;
    logic [1:0]             rresp;
    logic [1:0]             next_rresp;
    logic [31:0]            rdata;
    logic [31:0]            next_rdata;
    logic                   wr_go;
    logic                   rd_go;
    logic [31:0]            status_word;
    logic [31:0]            ctrl_word;

    assign wr_go         = clk_en && s_axi_awvalid && s_axi_wvalid && !bvalid;
    assign rd_go         = clk_en && s_axi_arvalid && !rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rresp   = rresp;
    assign s_axi_rdata   = rdata;
    assign ctrl_word     = {{(32-`CTRL_WIDTH){1'b0}}, ctrl};

    always_comb
    begin
        next_ctrl   = ctrl;
        next_bvalid = bvalid;
        next_bresp  = bresp;
        next_rvalid = rvalid;
        next_rresp  = rresp;
        next_rdata  = rdata;
        if (clk_en && bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        if (clk_en && rvalid && s_axi_rready)
            next_rvalid = 1'b0;
        if (wr_go)
        begin
            next_bvalid = 1'b1;
            next_bresp  = `RESP_OKAY;
            if (s_axi_awaddr[ADDR_W-1:2] == (ADDR_W-2)'(`CTRL_OFFSET >> 2))
            begin
                if (s_axi_wstrb[0])
                    next_ctrl[7:0] = s_axi_wdata[7:0];
                if (s_axi_wstrb[1])
                    next_ctrl[`CTRL_WIDTH-1:8] = s_axi_wdata[`CTRL_WIDTH-1:8];
            end
            else if (s_axi_awaddr[ADDR_W-1:2] != (ADDR_W-2)'(`STATUS_OFFSET >> 2))
                next_bresp = `RESP_SLVERR;
        end
        if (rd_go)
        begin
            next_rvalid = 1'b1;
            next_rresp  = `RESP_OKAY;
            if (s_axi_araddr[ADDR_W-1:2] == (ADDR_W-2)'(`CTRL_OFFSET >> 2))
                next_rdata = ctrl_word;
            else if (s_axi_araddr[ADDR_W-1:2] == (ADDR_W-2)'(`STATUS_OFFSET >> 2))
                next_rdata = status_word;
            else
            begin
                next_rdata = 32'h0;
                next_rresp = `RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl   <= `CTRL_RESET;
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
            rvalid <= 1'b0;
            rresp  <= `RESP_OKAY;
            rdata  <= 32'h0;
        end
        else
        begin
            ctrl   <= next_ctrl;
            bvalid <= next_bvalid;
            bresp  <= next_bresp;
            rvalid <= next_rvalid;
            rresp  <= next_rresp;
            rdata  <= next_rdata;
        end
    end

    // muting cycle, error latch, power-up window
    mute_state_e state;
    mute_state_e next_state;
    logic        error_held;
    logic        next_error_held;
    logic        beam_seen;
    logic        next_beam_seen;
    logic        passage_done;
    logic        next_passage_done;
    logic [31:0] show_count;
    logic [31:0] next_show_count;
    logic        pair;
    logic        muted;
    logic        showing;

    assign pair    = sens_1 && sens_2;
    assign muted   = state == MUTE_ON;
    assign showing = show_count != 32'(SHOW_CYCLES);

    always_comb
    begin
        next_state        = state;
        next_error_held   = error_held;
        next_beam_seen    = beam_seen;
        next_passage_done = passage_done;
        next_show_count   = show_count;
        if (clk_en)
        begin
            if (internal_error)
                next_error_held = 1'b1;
            if (showing)
                next_show_count = show_count + 32'h1;
            case (state)
                MUTE_IDLE:
                begin
                    next_beam_seen    = 1'b0;
                    next_passage_done = 1'b0;
                    if (pair)
                        next_state = MUTE_ON;
                    else if (sens_1 || sens_2)
                        next_state = MUTE_ARMED;
                end
                MUTE_ARMED:
                begin
                    if (pair)
                        next_state = MUTE_ON;
                    else if (!sens_1 && !sens_2)
                        next_state = MUTE_IDLE;
                end
                MUTE_ON:
                begin
                    if (beam)
                        next_beam_seen = 1'b1;
                    if (beam_seen && !beam)
                        next_passage_done = 1'b1;
                    if (!pair)
                        next_state = MUTE_TAIL;
                    else if (ctrl[`CTRL_EXIT_MON] && passage_done && beam)
                        next_state = MUTE_TAIL;
                end
                MUTE_TAIL:
                begin
                    if (!sens_1 && !sens_2)
                        next_state = MUTE_IDLE;
                end
                default:
                    next_state = MUTE_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state        <= MUTE_IDLE;
            error_held   <= 1'b0;
            beam_seen    <= 1'b0;
            passage_done <= 1'b0;
            show_count   <= 32'h0;
        end
        else
        begin
            state        <= next_state;
            error_held   <= next_error_held;
            beam_seen    <= next_beam_seen;
            passage_done <= next_passage_done;
            show_count   <= next_show_count;
        end
    end

    assign status_word = {24'h0, showing, passage_done, error_held, beam, sens_2, sens_1, muted, outputs_on};

    // outputs and indication
    logic blink_1hz;
    logic blink_2hz;
    blink_divider #(
        .HALF_CYCLES (HALF_CYCLES)
    ) u_blink (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .blink_1hz (blink_1hz),
        .blink_2hz (blink_2hz)
    );

    logic   hold_off;
    logic   next_on;
    logic   next_red;
    logic   next_green;
    logic   next_yellow;
    glyph_t glyph;
    glyph_t next_seg;

    assign hold_off = error_held || ctrl[`CTRL_RESET_REQ] || ctrl[`CTRL_OVERRIDE_REQ];

    always_comb
    begin
        next_on     = !hold_off && (!beam || muted);
        next_red    = !next_on;
        next_green  = next_on && !muted;
        next_yellow = next_on && muted;
        if (ctrl[`CTRL_RESET_REQ] && !error_held)
        begin
            next_yellow = blink_1hz;
            next_red    = !blink_1hz;
        end
        else if (ctrl[`CTRL_OVERRIDE_REQ] && !error_held)
        begin
            next_yellow = blink_2hz;
            next_red    = !blink_2hz;
        end
        glyph = `GLYPH_BLANK;
        if (error_held)
            glyph = `GLYPH_ERROR;
        else if (ctrl[`CTRL_SENDER] && ctrl[`CTRL_TEST_MODE])
            glyph = `GLYPH_TEST;
        else if (showing && !ctrl[`CTRL_SENDER] && ctrl[`CTRL_EXT_RANGE])
            glyph = `GLYPH_RANGE;
        else if (showing)
            case (ctrl[`CTRL_CODE_LO+1:`CTRL_CODE_LO])
                2'h1:    glyph = `GLYPH_CODE1;
                2'h2:    glyph = `GLYPH_CODE2;
                default: glyph = `GLYPH_NOCODE;
            endcase
        else if (!ctrl[`CTRL_SENDER])
        begin
            if (ctrl[`CTRL_POOR_ALIGN])
                glyph = `GLYPH_ALIGN;
            else if (ctrl[`CTRL_OVERRIDE_REQ])
                glyph = `GLYPH_OVERRIDE;
            else if (muted)
                glyph = `GLYPH_MUTING;
            else if (ctrl[`CTRL_BLANKING])
                glyph = `GLYPH_BLANKING;
            else if (beam)
                glyph = `GLYPH_BROKEN;
        end
        // half turn swaps a/d, b/e, c/f
        next_seg = ctrl[`CTRL_ROTATE] ? {glyph[6], glyph[2:0], glyph[5:3]} : glyph;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            outputs_on    <= 1'b0;
            cap_red       <= 1'b1;
            cap_green     <= 1'b0;
            cap_yellow    <= 1'b0;
            lamp_red      <= 1'b1;
            lamp_green    <= 1'b0;
            lamp_orange   <= 1'b0;
            segments      <= `GLYPH_BLANK;
            segment_point <= 1'b1;
        end
        else if (clk_en)
        begin
            outputs_on    <= next_on;
            cap_red       <= next_red;
            cap_green     <= next_green;
            cap_yellow    <= next_yellow;
            lamp_red      <= !next_on;
            lamp_green    <= next_on;
            lamp_orange   <= ctrl[`CTRL_REALIGN];
            segments      <= next_seg;
            segment_point <= !ctrl[`CTRL_ROTATE];
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_muted_then_drop;
        muted ##0 (clk_en && !pair);
    endsequence

    property p_error_off;
        clk_en && error_held |=> !outputs_on && error_held;
    endproperty
    a_error_off: assert property (p_error_off) else $error("outputs on while error held");

    property p_reset_off;
        clk_en && ctrl[`CTRL_RESET_REQ] |=> !outputs_on && (cap_red != cap_yellow || error_held);
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("reset request not indicated");

    property p_override_off;
        clk_en && ctrl[`CTRL_OVERRIDE_REQ] |=> !outputs_on;
    endproperty
    a_override_off: assert property (p_override_off) else $error("outputs on during override");

    property p_beam_off;
        clk_en && beam && !muted |=> !outputs_on;
    endproperty
    a_beam_off: assert property (p_beam_off) else $error("unexplained interruption left outputs on");

    property p_mute_cause;
        $rose(muted) |-> $past(pair);
    endproperty
    a_mute_cause: assert property (p_mute_cause) else $error("muting without both sensors");

    property p_mute_end;
        s_muted_then_drop |=> !muted;
    endproperty
    a_mute_end: assert property (p_mute_end) else $error("muting kept after pair dropped");

    property p_no_rearm;
        state == MUTE_TAIL && (sens_1 || sens_2) |=> !muted;
    endproperty
    a_no_rearm: assert property (p_no_rearm) else $error("muting re-entered inside cycle");

    property p_point;
        clk_en |=> segment_point == !$past(ctrl[`CTRL_ROTATE]);
    endproperty
    a_point: assert property (p_point) else $error("point does not follow rotation");

    property p_exit_mon;
        clk_en && muted && ctrl[`CTRL_EXIT_MON] && passage_done && beam |=> !muted;
    endproperty
    a_exit_mon: assert property (p_exit_mon) else $error("second passage accepted");

    property p_clear_green;
        clk_en && !hold_off && !beam && !muted |=> cap_green && lamp_green && !cap_red;
    endproperty
    a_clear_green: assert property (p_clear_green) else $error("clear system not green");
endmodule : safety_status_muting
`default_nettype wire

// >>> verif/muting_partner.sv
// behavioural load passing a muting sensor pair and the light path
`timescale 1ns/100ps
`default_nettype none
module muting_partner (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic go,
    input  wire logic one_only,
    input  wire logic twice,
    output logic      first_muting_sensor,
    output logic      second_muting_sensor,
    output logic      beam_interrupted
);
    logic [5:0] step;
    logic [5:0] next_step;
    always_comb
    begin
        next_step = step;
        if (step != 6'h00) next_step = step + 6'h01;
        else if (go) next_step = 6'h01;
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n) step <= 6'h00;
        else step <= next_step;
    end
    // one unbroken level per sensor over the whole load, low when clear
    assign first_muting_sensor  = step >= 6'h01 && step <= 6'h32;
    assign second_muting_sensor = !one_only && step >= 6'h05 && step <= 6'h37;
    assign beam_interrupted     = (step >= 6'h0A && step <= 6'h14) || (twice && step >= 6'h1E && step <= 6'h28);
endmodule : muting_partner
`default_nettype wire

// >>> verif/tb_top.sv
// testbench for the status and muting block
`timescale 1ns/100ps
`default_nettype none
`include "safety_status_params.svh"
module tb_top;
    import safety_status_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        internal_error = 1'b0;
    logic        go = 1'b0;
    logic        clk_en = 1'b1;
    logic        one_only = 1'b0;
    logic        twice = 1'b0;
    logic        s1, s2, beam;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic        outputs_on, cap_red, cap_green, cap_yellow, lamp_orange, lamp_red, lamp_green, segment_point;
    glyph_t      segments;
    int          err_total = 0, checks = 0, cyc = 0, n, i;
    logic [11:0] ctrl_tab [5] = '{12'h200, 12'h400, 12'h008, 12'h810, 12'h811};
    // last entry: test glyph turned by half a turn, a/d, b/e, c/f swapped
    glyph_t      glyph_tab [5] = '{`GLYPH_ALIGN, `GLYPH_BLANKING, `GLYPH_OVERRIDE, `GLYPH_TEST, 7'h63};

    safety_status_muting #(.ADDR_W(4), .HALF_CYCLES(8), .SHOW_CYCLES(20)) safety_status_muting_inst (
        .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .first_muting_sensor(s1),
        .second_muting_sensor(s2), .beam_interrupted(beam), .internal_error(internal_error),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .outputs_on(outputs_on), .cap_red(cap_red), .cap_green(cap_green),
        .cap_yellow(cap_yellow), .lamp_orange(lamp_orange), .lamp_red(lamp_red), .lamp_green(lamp_green),
        .segments(segments), .segment_point(segment_point));
    muting_partner muting_partner_inst (
        .sys_clk(sys_clk), .reset_n(reset_n), .go(go), .one_only(one_only), .twice(twice),
        .first_muting_sensor(s1), .second_muting_sensor(s2), .beam_interrupted(beam));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH time=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
    endtask : tick
    task automatic wrap_up();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd_reg(input logic [3:0] a);
        @(posedge sys_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd_reg
    // one load through the sensor pair, checked in the first and second interruption
    task automatic pass(input logic one, input logic two, input logic exp_mid, input logic exp_late);
        one_only <= one;
        twice    <= two;
        go       <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(17);
        check(outputs_on, exp_mid);
        check(cap_yellow, exp_mid);
        check(lamp_red, !exp_mid);
        check(segments, exp_mid ? `GLYPH_MUTING : `GLYPH_BROKEN);
        tick(20);
        check(outputs_on, exp_late);
        tick(40);
    endtask : pass
    task automatic run_len(input logic yel, input int exp);
        if (yel) while (cap_yellow === 1'b1) tick(1);
        while ((yel ? cap_yellow : cap_red) !== 1'b1) tick(1);
        n = 0;
        while ((yel ? cap_yellow : cap_red) === 1'b1)
        begin
            tick(1);
            n++;
        end
        check(n, exp);
    endtask : run_len

    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total++;
            wrap_up();
        end
    end

    initial
    begin
        tick(5);
        reset_n <= 1'b1;
        tick(2);
        check(segments, `GLYPH_NOCODE);
        wr(`CTRL_OFFSET, 32'h0000_0040);
        tick(2);
        check(segments, `GLYPH_CODE1);
        check(segment_point, 1'b1);
        wr(`CTRL_OFFSET, 32'h0000_0020);
        tick(2);
        check(segments, `GLYPH_RANGE);
        wr(`CTRL_OFFSET, 32'h0000_0080);
        tick(2);
        check(segments, `GLYPH_CODE2);
        tick(25);
        check(segments, `GLYPH_BLANK);
        check(outputs_on, 1'b1);
        check(cap_green, 1'b1);
        check(lamp_green, 1'b1);
        $display("power-up test done");
        rd_reg(`CTRL_OFFSET);
        check(rd, 32'h0000_0080);
        wr(4'hC, 32'h0000_0FFF);
        check(resp, `RESP_SLVERR);
        rd_reg(4'h8);
        check(resp, `RESP_SLVERR);
        check(rd, 32'h0);
        wr(`STATUS_OFFSET, 32'h0000_00FF);
        check(resp, `RESP_OKAY);
        rd_reg(`STATUS_OFFSET);
        check(rd, 32'h0000_0001);
        $display("register test done");
        wr(`CTRL_OFFSET, 32'h0000_0101);
        tick(2);
        check(segment_point, 1'b0);
        check(lamp_orange, 1'b1);
        for (i = 0; i < 5; i++)
        begin
            wr(`CTRL_OFFSET, {20'h0, ctrl_tab[i]});
            tick(2);
            check(segments, glyph_tab[i]);
        end
        $display("indication test done");
        wr(`CTRL_OFFSET, 32'h0);
        tick(3);
        pass(1'b0, 1'b1, 1'b1, 1'b1);
        check(outputs_on, 1'b1);
        rd_reg(`STATUS_OFFSET);
        check(rd[1], 1'b0);
        pass(1'b1, 1'b0, 1'b0, 1'b1);
        wr(`CTRL_OFFSET, 32'h0000_0002);
        pass(1'b0, 1'b1, 1'b1, 1'b0);
        $display("muting test done");
        wr(`CTRL_OFFSET, 32'h0000_0004);
        tick(2);
        check(outputs_on, 1'b0);
        run_len(1'b1, 8);
        run_len(1'b0, 8);
        wr(`CTRL_OFFSET, 32'h0000_0008);
        run_len(1'b1, 4);
        run_len(1'b0, 4);
        clk_en <= 1'b0;
        tick(2);
        n = cap_yellow;
        tick(4);
        check(cap_yellow, n);
        clk_en <= 1'b1;
        check(outputs_on, 1'b0);
        $display("blink test done");
        wr(`CTRL_OFFSET, 32'h0);
        internal_error <= 1'b1;
        tick(1);
        internal_error <= 1'b0;
        tick(6);
        check(segments, `GLYPH_ERROR);
        check(outputs_on, 1'b0);
        check(cap_red, 1'b1);
        rd_reg(`STATUS_OFFSET);
        check(rd[5], 1'b1);
        reset_n <= 1'b0;
        tick(5);
        check(outputs_on, 1'b0);
        reset_n <= 1'b1;
        tick(30);
        check(segments, `GLYPH_BLANK);
        check(outputs_on, 1'b1);
        $display("error test done");
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
